/* pkg/clk_ctrl_pkg.sv */
package clk_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int REG_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_CTRL_C = 8'h08;
    localparam logic [7:0] OFF_SRC_SEL = 8'h0C;
    localparam logic [7:0] OFF_ONCHIP_OSC = 8'h10;
    localparam logic [7:0] OFF_HS_DIV = 8'h14;
    localparam logic [7:0] OFF_PROTECT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;

    // field positions
    localparam int A_PERIPH_WAIT_STOP = 2;
    localparam int A_CRYSTAL_STOP = 5;
    localparam int A_DIV8 = 6;
    localparam int B_PIN_EN = 3;
    localparam int B_LS_DISABLE = 4;
    localparam int B_DIV_LO = 6;
    localparam int B_DIV_HI = 7;
    localparam int C_WAKE_OVERRIDE = 5;
    localparam int S_ONCHIP_SEL = 2;
    localparam int O_HS_EN = 0;
    localparam int O_OSC_SEL = 1;
    localparam int O_SLOW_CAP = 3;
    localparam int H_DIV_LSB = 0;
    localparam int P_PROTECT = 7;
    localparam int ST_CRYSTAL_MODE = 0;
    localparam int ST_HS_MODE = 1;
    localparam int ST_LS_MODE = 2;
    localparam int ST_SRC_LSB = 3;
    localparam int ST_PERIPH_RUN = 5;
    localparam int ST_SYS_LEVEL = 6;

    // values after reset
    localparam logic RST_DIV8 = 1'b0;
    localparam logic RST_CRYSTAL_STOP = 1'b1;
    localparam logic RST_PERIPH_WAIT_STOP = 1'b0;
    localparam logic [1:0] RST_DIV_FIELD = 2'h0;
    localparam logic RST_PIN_EN = 1'b0;
    localparam logic RST_LS_DISABLE = 1'b0;
    localparam logic RST_WAKE_OVERRIDE = 1'b0;
    localparam logic RST_ONCHIP_SEL = 1'b1;
    localparam logic RST_HS_EN = 1'b0;
    localparam logic RST_OSC_SEL = 1'b0;
    localparam logic RST_SLOW_CAP = 1'b0;
    localparam logic [2:0] RST_HS_DIV = 3'h0;
    localparam logic RST_PROTECT = 1'b0;

    // divider counts, in source transitions per output half period
    localparam int RATIO_W = 5;
    localparam logic [4:0] HALF_DIV1 = 5'h01;
    localparam logic [4:0] HALF_DIV2 = 5'h02;
    localparam logic [4:0] HALF_DIV4 = 5'h04;
    localparam logic [4:0] HALF_DIV8 = 5'h08;
    localparam logic [4:0] HALF_DIV16 = 5'h10;
    localparam logic [4:0] HS_DIV_BASE = 5'h02;
    localparam int PERIPH_CNT_W = 5;
    localparam int CAP_CNT_W = 7;

    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'b00,
        SRC_LS = 2'b01,
        SRC_HS = 2'b11
    } sys_src_e;
endpackage : clk_ctrl_pkg

/* rtl/system_clock_divider_and_mode_select.sv */
// Behaviour
// R1 - system clock from crystal or on-chip oscillator
// R2 - cpu divide: div8 bit, else 1/2/4/16
// R3 - after reset cpu runs low-speed, undivided
// R4 - stop entry forces divide-by-eight bit
// R5 - software clears wake override before stop
// R6 - five peripheral clocks: divide 1,2,4,8,32
// R7 - peripheral clocks gated in wait when asked
// R8 - on-chip output follows selected oscillator
// R9 - high-speed timer clock gated by enable
// R10 - high-speed divided clock, ratio 2 to 9
// R11 - low-speed derived clock runs while enabled
// R12 - divide-by-128 of low or high source
// R13 - divide-by-128 drives two timer captures
// R14 - watchdog clock enabled, never stops when protected
// R15 - mode decode of source and enable bits
// R16 - software switches only to stable sources
// R17 - low-current read needs divide 4,8,16 first
// R18 - software sets low-power bit before wait
// R19 - high-speed oscillator used when enabled, selected; the code switches to it when selected, enabled or not
// R20 - switching never produces shortened clock pulses; on-chip output and capture source muxes switch unguarded
//
// The placing of the registers and the APB register port were chosen for this implementation.

module osc_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic osc,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= osc;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s2;
            end
        end
    end
endmodule : osc_sync

// settings are taken only while the output is low, so no pulse is ever cut short
module clk_div_stage #(
    parameter logic [4:0] RST_RATIO = 5'h01
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic srcChange,
    input wire logic [4:0] ratio,
    input wire logic en,
    output logic out
);
    logic [4:0] cnt;
    logic [4:0] actRatio;
    logic actEn;
    logic [4:0] cntInc;
    logic wrap;

    assign cntInc = cnt + 5'h01;
    assign wrap = cntInc >= actRatio;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 5'h00;
            out <= 1'b0;
            actRatio <= RST_RATIO;
            actEn <= 1'b1;
        end else if (srcChange) begin
            if (wrap) begin
                cnt <= 5'h00;
                if (out) begin
                    out <= 1'b0;
                    actRatio <= ratio; // R20
                    actEn <= en;
                end else begin
                    out <= actEn;
                end
            end else begin
                cnt <= cntInc;
            end
        end else if (!out) begin
            // a halt taken while low lets no extra high phase out
            actRatio <= ratio;
            actEn <= en;
        end
    end
endmodule : clk_div_stage

module system_clock_divider_and_mode_select (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator inputs
    input wire logic crystalClk,
    input wire logic hsOscClk,
    input wire logic lsOscClk,
    input wire logic wdtOscClk,
    // power mode indications from the core
    input wire logic waitMode,
    input wire logic stopMode,
    // cpu and peripheral clocks
    output logic cpuClk,
    output logic periphDivClk1,
    output logic periphDivClk2,
    output logic periphDivClk4,
    output logic periphDivClk8,
    output logic periphDivClk32,
    // oscillator derived clocks
    output logic onchipClkOut,
    output logic hsTimerClk,
    output logic hsDividedClk,
    output logic lsDerivedClk,
    output logic timerGeneralRegACapture,
    output logic timer2Ch0Capture,
    output logic watchdogOscClk
);
    // control bits
    logic cpuDiv8Sel;
    logic crystalOscStop;
    logic periphClkWaitStop;
    logic cpuDivFieldLo;
    logic cpuDivFieldHi;
    logic crystalPinEnable;
    logic lowspeedOscDisable;
    logic wakeClockOverride;
    logic sysSrcOnchipSel;
    logic highspeedOscEnable;
    logic onchipOscSelect;
    logic slowCaptureSrcSel;
    logic [2:0] hsDivField;
    logic countSrcProtectEn;

    // clock state
    logic crystalLevel;
    logic hsLevel;
    logic lsLevel;
    logic wdtLevel;
    clk_ctrl_pkg::sys_src_e sysSrc;
    clk_ctrl_pkg::sys_src_e wantSrc;
    logic sysLevel;
    logic hsPrev;
    logic capPrev;
    logic stopPrev;
    logic periphRun;
    logic [4:0] periphCnt;
    logic [6:0] capCnt;

    osc_sync u_sync_crystal (.clk(clk), .rstn(rstn), .osc(crystalClk), .level(crystalLevel));
    osc_sync u_sync_hs (.clk(clk), .rstn(rstn), .osc(hsOscClk), .level(hsLevel));
    osc_sync u_sync_ls (.clk(clk), .rstn(rstn), .osc(lsOscClk), .level(lsLevel));
    osc_sync u_sync_wdt (.clk(clk), .rstn(rstn), .osc(wdtOscClk), .level(wdtLevel));

    // apb decode
    wire setup = psel & ~penable;
    wire wrEn = psel & penable & pready & pwrite;
    wire hitA = paddr == clk_ctrl_pkg::OFF_CTRL_A;
    wire hitB = paddr == clk_ctrl_pkg::OFF_CTRL_B;
    wire hitC = paddr == clk_ctrl_pkg::OFF_CTRL_C;
    wire hitSrc = paddr == clk_ctrl_pkg::OFF_SRC_SEL;
    wire hitOsc = paddr == clk_ctrl_pkg::OFF_ONCHIP_OSC;
    wire hitHs = paddr == clk_ctrl_pkg::OFF_HS_DIV;
    wire hitProt = paddr == clk_ctrl_pkg::OFF_PROTECT;
    wire hitStat = paddr == clk_ctrl_pkg::OFF_STATUS;
    wire mapped = hitA | hitB | hitC | hitSrc | hitOsc | hitHs | hitProt | hitStat;
    wire stopRise = stopMode & ~stopPrev;

    // gated oscillator levels
    wire crystalGated = crystalLevel & crystalPinEnable & ~crystalOscStop;
    wire hsGated = hsLevel & highspeedOscEnable; // R9
    wire lsGated = lsLevel & ~lowspeedOscDisable; // R11

    // mode decode
    wire crystalMode = ~sysSrcOnchipSel & crystalPinEnable & ~crystalOscStop; // R15
    wire hsOnchipMode = sysSrcOnchipSel & onchipOscSelect & highspeedOscEnable; // R15
    wire lsOnchipMode = sysSrcOnchipSel & ~lowspeedOscDisable & ~onchipOscSelect; // R15

    // high-speed whenever selected, enabled or not; a disabled one stays low
    always_comb begin
        if (!sysSrcOnchipSel) begin
            wantSrc = clk_ctrl_pkg::SRC_CRYSTAL; // R1
        end else if (onchipOscSelect) begin
            wantSrc = clk_ctrl_pkg::SRC_HS; // R19
        end else begin
            wantSrc = clk_ctrl_pkg::SRC_LS;
        end
    end

    function automatic logic srcLevel(input clk_ctrl_pkg::sys_src_e s, input logic xl,
                                      input logic hl, input logic ll);
        logic r;
        r = 1'b0;
        unique case (s)
            clk_ctrl_pkg::SRC_CRYSTAL: r = xl;
            clk_ctrl_pkg::SRC_HS: r = hl;
            clk_ctrl_pkg::SRC_LS: r = ll;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : srcLevel

    wire sysNow = srcLevel(sysSrc, crystalGated, hsGated, lsGated); // R1
    wire wantNow = srcLevel(wantSrc, crystalGated, hsGated, lsGated);
    wire sysChange = sysNow ^ sysLevel;
    wire sysRise = sysNow & ~sysLevel;
    wire sysFall = ~sysNow & sysLevel;

    // switch only while both old and new sources are low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sysSrc <= clk_ctrl_pkg::SRC_LS; // R3
            sysLevel <= 1'b0;
        end else begin
            if (!sysNow && !wantNow) begin
                sysSrc <= wantSrc; // R20
            end
            sysLevel <= sysNow;
        end
    end

    // cpu divider
    logic [4:0] cpuRatio;
    always_comb begin
        cpuRatio = clk_ctrl_pkg::HALF_DIV1;
        if (cpuDiv8Sel) begin
            cpuRatio = clk_ctrl_pkg::HALF_DIV8; // R2
        end else begin
            unique case ({cpuDivFieldHi, cpuDivFieldLo})
                2'b00: cpuRatio = clk_ctrl_pkg::HALF_DIV1; // R2
                2'b01: cpuRatio = clk_ctrl_pkg::HALF_DIV2;
                2'b10: cpuRatio = clk_ctrl_pkg::HALF_DIV4;
                2'b11: cpuRatio = clk_ctrl_pkg::HALF_DIV16;
            endcase
        end
    end

    // the cpu clock halts in wait and stop; the core relies on it
    clk_div_stage #(.RST_RATIO(clk_ctrl_pkg::HALF_DIV1)) u_cpu_div (
        .clk(clk),
        .rstn(rstn),
        .srcChange(sysChange),
        .ratio(cpuRatio),
        .en(~(waitMode | stopMode)),
        .out(cpuClk)
    );

    // high-speed divided clock, ratio field plus two
    wire [4:0] hsRatio = clk_ctrl_pkg::HS_DIV_BASE + {2'b00, hsDivField}; // R10
    clk_div_stage #(.RST_RATIO(clk_ctrl_pkg::HS_DIV_BASE)) u_hs_div (
        .clk(clk),
        .rstn(rstn),
        .srcChange(hsGated ^ hsPrev),
        .ratio(hsRatio),
        .en(highspeedOscEnable), // R10
        .out(hsDividedClk)
    );

    // divide-by-128 capture source
    wire capLevel = slowCaptureSrcSel ? hsDividedClk : lsGated; // R12
    wire capRise = capLevel & ~capPrev;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hsPrev <= 1'b0;
            capPrev <= 1'b0;
            capCnt <= 7'h00;
            timerGeneralRegACapture <= 1'b0;
            timer2Ch0Capture <= 1'b0;
        end else begin
            hsPrev <= hsGated;
            capPrev <= capLevel;
            if (capRise) begin
                capCnt <= capCnt + 7'h01; // R12
            end
            timerGeneralRegACapture <= capCnt[clk_ctrl_pkg::CAP_CNT_W - 1]; // R13
            timer2Ch0Capture <= capCnt[clk_ctrl_pkg::CAP_CNT_W - 1]; // R13
        end
    end

    // peripheral clocks; the gate moves only when every output is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periphRun <= 1'b1;
            periphCnt <= 5'h00;
            periphDivClk1 <= 1'b0;
            periphDivClk2 <= 1'b0;
            periphDivClk4 <= 1'b0;
            periphDivClk8 <= 1'b0;
            periphDivClk32 <= 1'b0;
        end else begin
            if (sysRise) begin
                periphCnt <= periphCnt + 5'h01; // R6
            end
            if (sysFall && periphCnt == 5'h00) begin
                periphRun <= ~(periphClkWaitStop & waitMode); // R7 R20
            end
            periphDivClk1 <= periphRun & sysNow; // R6
            periphDivClk2 <= periphRun & periphCnt[0];
            periphDivClk4 <= periphRun & periphCnt[1];
            periphDivClk8 <= periphRun & periphCnt[2];
            periphDivClk32 <= periphRun & periphCnt[4];
        end
    end

    // oscillator outputs; none of them look at wait mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            onchipClkOut <= 1'b0;
            hsTimerClk <= 1'b0;
            lsDerivedClk <= 1'b0;
            watchdogOscClk <= 1'b0;
        end else begin
            onchipClkOut <= onchipOscSelect ? hsDividedClk : lsGated; // R8
            hsTimerClk <= hsGated; // R9
            lsDerivedClk <= lsGated; // R11
            watchdogOscClk <= wdtLevel & countSrcProtectEn; // R14
        end
    end

    // control registers; the stop-entry set beats a same-cycle write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stopPrev <= 1'b0;
            cpuDiv8Sel <= clk_ctrl_pkg::RST_DIV8;
            crystalOscStop <= clk_ctrl_pkg::RST_CRYSTAL_STOP;
            periphClkWaitStop <= clk_ctrl_pkg::RST_PERIPH_WAIT_STOP;
            {cpuDivFieldHi, cpuDivFieldLo} <= clk_ctrl_pkg::RST_DIV_FIELD;
            crystalPinEnable <= clk_ctrl_pkg::RST_PIN_EN;
            lowspeedOscDisable <= clk_ctrl_pkg::RST_LS_DISABLE;
            wakeClockOverride <= clk_ctrl_pkg::RST_WAKE_OVERRIDE;
            sysSrcOnchipSel <= clk_ctrl_pkg::RST_ONCHIP_SEL;
            highspeedOscEnable <= clk_ctrl_pkg::RST_HS_EN;
            onchipOscSelect <= clk_ctrl_pkg::RST_OSC_SEL;
            slowCaptureSrcSel <= clk_ctrl_pkg::RST_SLOW_CAP;
            hsDivField <= clk_ctrl_pkg::RST_HS_DIV;
            countSrcProtectEn <= clk_ctrl_pkg::RST_PROTECT;
        end else begin
            stopPrev <= stopMode;
            if (stopRise) begin
                cpuDiv8Sel <= 1'b1; // R4
            end else if (wrEn && hitA) begin
                cpuDiv8Sel <= pwdata[clk_ctrl_pkg::A_DIV8];
            end
            if (wrEn && hitA) begin
                crystalOscStop <= pwdata[clk_ctrl_pkg::A_CRYSTAL_STOP];
                periphClkWaitStop <= pwdata[clk_ctrl_pkg::A_PERIPH_WAIT_STOP];
            end
            if (wrEn && hitB) begin
                cpuDivFieldLo <= pwdata[clk_ctrl_pkg::B_DIV_LO];
                cpuDivFieldHi <= pwdata[clk_ctrl_pkg::B_DIV_HI];
                crystalPinEnable <= pwdata[clk_ctrl_pkg::B_PIN_EN];
                lowspeedOscDisable <= pwdata[clk_ctrl_pkg::B_LS_DISABLE];
            end
            if (wrEn && hitC) begin
                wakeClockOverride <= pwdata[clk_ctrl_pkg::C_WAKE_OVERRIDE];
            end
            if (wrEn && hitSrc) begin
                sysSrcOnchipSel <= pwdata[clk_ctrl_pkg::S_ONCHIP_SEL];
            end
            if (wrEn && hitOsc) begin
                highspeedOscEnable <= pwdata[clk_ctrl_pkg::O_HS_EN];
                onchipOscSelect <= pwdata[clk_ctrl_pkg::O_OSC_SEL];
                slowCaptureSrcSel <= pwdata[clk_ctrl_pkg::O_SLOW_CAP];
            end
            if (wrEn && hitHs) begin
                hsDivField <= pwdata[clk_ctrl_pkg::H_DIV_LSB +: 3];
            end
            // once set, only reset clears it, so the watchdog clock cannot stop
            if (wrEn && hitProt && pwdata[clk_ctrl_pkg::P_PROTECT]) begin
                countSrcProtectEn <= 1'b1; // R14
            end
        end
    end

    // read mux
    logic [7:0] readData;
    always_comb begin
        readData = 8'h00;
        if (hitA) begin
            readData[clk_ctrl_pkg::A_DIV8] = cpuDiv8Sel;
            readData[clk_ctrl_pkg::A_CRYSTAL_STOP] = crystalOscStop;
            readData[clk_ctrl_pkg::A_PERIPH_WAIT_STOP] = periphClkWaitStop;
        end else if (hitB) begin
            readData[clk_ctrl_pkg::B_DIV_LO] = cpuDivFieldLo;
            readData[clk_ctrl_pkg::B_DIV_HI] = cpuDivFieldHi;
            readData[clk_ctrl_pkg::B_PIN_EN] = crystalPinEnable;
            readData[clk_ctrl_pkg::B_LS_DISABLE] = lowspeedOscDisable;
        end else if (hitC) begin
            readData[clk_ctrl_pkg::C_WAKE_OVERRIDE] = wakeClockOverride;
        end else if (hitSrc) begin
            readData[clk_ctrl_pkg::S_ONCHIP_SEL] = sysSrcOnchipSel;
        end else if (hitOsc) begin
            readData[clk_ctrl_pkg::O_HS_EN] = highspeedOscEnable;
            readData[clk_ctrl_pkg::O_OSC_SEL] = onchipOscSelect;
            readData[clk_ctrl_pkg::O_SLOW_CAP] = slowCaptureSrcSel;
        end else if (hitHs) begin
            readData[clk_ctrl_pkg::H_DIV_LSB +: 3] = hsDivField;
        end else if (hitProt) begin
            readData[clk_ctrl_pkg::P_PROTECT] = countSrcProtectEn;
        end else if (hitStat) begin
            readData[clk_ctrl_pkg::ST_CRYSTAL_MODE] = crystalMode;
            readData[clk_ctrl_pkg::ST_HS_MODE] = hsOnchipMode;
            readData[clk_ctrl_pkg::ST_LS_MODE] = lsOnchipMode;
            readData[clk_ctrl_pkg::ST_SRC_LSB +: 2] = sysSrc;
            readData[clk_ctrl_pkg::ST_PERIPH_RUN] = periphRun;
            readData[clk_ctrl_pkg::ST_SYS_LEVEL] = sysLevel;
        end
    end

    // answer is prepared in the setup cycle, ready for the access cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= {24'h000000, readData};
            end
        end
    end
endmodule : system_clock_divider_and_mode_select

/* test/clk_ctrl_asserts.sv */
module clk_ctrl_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // power modes
    input wire logic waitMode,
    input wire logic stopMode,
    // oscillator and clock outputs
    input wire logic wdtOscClk,
    input wire logic cpuClk,
    input wire logic periphDivClk1,
    input wire logic watchdogOscClk,
    input wire logic timerGeneralRegACapture,
    input wire logic timer2Ch0Capture
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // saturates, so a long wait never wraps back to a small count
    logic [3:0] idleCnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idleCnt <= 4'h0;
        end else if (!(waitMode || stopMode)) begin
            idleCnt <= 4'h0;
        end else if (idleCnt != 4'hF) begin
            idleCnt <= idleCnt + 4'h1;
        end
    end
    chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a one cycle answer");
    chk_err_ready: assert property (pslverr |-> pready && psel)
        else $error("pslverr outside an answer");
    chk_cap_same: assert property (timerGeneralRegACapture == timer2Ch0Capture)
        else $error("capture outputs differ");
    chk_cpu_high: assert property ($rose(cpuClk) |-> cpuClk [*3])
        else $error("short cpu high phase");
    chk_cpu_low: assert property ($fell(cpuClk) |-> !cpuClk [*3])
        else $error("short cpu low phase");
    chk_periph_high: assert property ($rose(periphDivClk1) |-> periphDivClk1 [*3])
        else $error("short peripheral high phase");
    chk_cpu_halt: assert property ($rose(cpuClk) |-> idleCnt < 4'hC)
        else $error("cpu clock rose in a held low power mode");
    // output lags the pin by the synchroniser and filter depth
    chk_wdt_src: assert property (watchdogOscClk |->
        $past(wdtOscClk, 4) || $past(wdtOscClk, 5) || $past(wdtOscClk, 6) || $past(wdtOscClk, 7))
        else $error("watchdog clock high without its oscillator");
    cov_cpu: cover property ($rose(cpuClk));
    cov_err: cover property (pslverr);
    cov_cap: cover property ($rose(timerGeneralRegACapture));
endmodule : clk_ctrl_asserts

bind system_clock_divider_and_mode_select clk_ctrl_asserts i_chk (.*);

/* test/clk_consumer.sv */
// stands in for a cpu or timer: times each clock it is handed
module clk_consumer (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // clock under watch
    input wire logic tck,
    // cycles between the last two rises, and rises seen
    output logic [31:0] period,
    output logic [31:0] rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;
    logic [31:0] age;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last <= 1'b0;
            age <= 32'h0;
            period <= 32'h0;
            rises <= 32'h0;
        end else begin
            last <= tck;
            age <= (tck && !last) ? 32'h1 : age + 32'h1;
            if (tck && !last) begin
                period <= age;
                rises <= rises + 32'h1;
            end
        end
    end
endmodule : clk_consumer

/* test/tb_system_clock_divider_and_mode_select.sv */
module tb_system_clock_divider_and_mode_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, waitMode, stopMode, err;
    logic crystalClk, hsOscClk, lsOscClk, wdtOscClk, cpuClk, onchipClkOut, hsTimerClk;
    logic periphDivClk1, periphDivClk2, periphDivClk4, periphDivClk8, periphDivClk32;
    logic hsDividedClk, lsDerivedClk, timerGeneralRegACapture, timer2Ch0Capture;
    logic watchdogOscClk;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [12:0] ck;
    wire [31:0] per [13];
    wire [31:0] ris [13];
    int cyc, badCount, checked;
    logic [7:0] rstVal [7] = '{8'h20, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    logic [7:0] rowA [5] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h60};
    logic [7:0] rowB [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hC0};
    int rowP [5] = '{8, 16, 32, 128, 64};

    system_clock_divider_and_mode_select i_dut (.*);
    assign ck = {timer2Ch0Capture, periphDivClk8, periphDivClk4, periphDivClk2,
        onchipClkOut, hsTimerClk, watchdogOscClk, lsDerivedClk,
        timerGeneralRegACapture, hsDividedClk, periphDivClk32, periphDivClk1, cpuClk};
    for (genvar g = 0; g < 13; g++) begin : g_mon
        clk_consumer i_mon (.clk(clk), .rstn(rstn), .tck(ck[g]), .period(per[g]),
            .rises(ris[g]));
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // oscillators run at whole-cycle periods so measured periods are exact
    always @(posedge clk) begin
        cyc <= cyc + 1;
        lsOscClk <= (cyc % 8) < 4;
        hsOscClk <= (cyc % 6) < 3;
        crystalClk <= (cyc % 10) < 5;
        wdtOscClk <= (cyc % 12) < 6;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, exp);
    endtask : rd

    task automatic pc(input int k, input int exp, input int w);
        repeat (w) @(posedge clk);
        chk(per[k], 32'(exp));
    endtask : pc

    // settle first, then see whether any rise lands in a fresh window
    task automatic runs(input int k, input logic exp);
        logic [31:0] r0;
        repeat (300) @(posedge clk);
        r0 = ris[k];
        repeat (300) @(posedge clk);
        chk(32'(ris[k] != r0), 32'(exp));
    endtask : runs

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (60000) @(posedge clk);
        badCount++;
        stop_test();
    end

    initial begin
        cyc = 0;
        rstn = 1'b0;
        {psel, penable, pwrite, waitMode, stopMode} = 5'h00;
        {crystalClk, hsOscClk, lsOscClk, wdtOscClk} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), {24'h0, rstVal[i]}, 32'hFF);
        end
        rd(8'h1C, 32'h2C, 32'h3F);
        pc(0, 8, 200);
        runs(5, 1'b1);
        runs(7, 1'b0);
        runs(6, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, {24'h0, rowA[i]});
            wr(8'h04, {24'h0, rowB[i]});
            pc(0, rowP[i], 500);
        end
        rd(8'h04, 32'h80, 32'h80);
        pc(1, 8, 0);
        pc(2, 256, 600);
        pc(9, 16, 0);
        pc(10, 32, 0);
        pc(11, 64, 0);
        wr(8'h14, 32'h07);
        wr(8'h10, 32'h03);
        pc(3, 54, 600);
        pc(8, 54, 0);
        pc(7, 6, 0);
        rd(8'h1C, 32'h3A, 32'h3F);
        wr(8'h14, 32'h00);
        pc(3, 12, 600);
        pc(4, 1024, 0);
        pc(12, 1024, 0);
        wr(8'h10, 32'h0B);
        pc(4, 1536, 4500);
        wr(8'h00, 32'h24);
        rd(8'h1C, 32'h00, 32'h04);
        waitMode <= 1'b1;
        runs(1, 1'b0);
        runs(0, 1'b0);
        runs(8, 1'b1);
        runs(3, 1'b1);
        runs(5, 1'b1);
        wr(8'h00, 32'h20);
        runs(1, 1'b1);
        waitMode <= 1'b0;
        wr(8'h04, 32'h18);
        runs(5, 1'b0);
        wr(8'h00, 32'h00);
        // crystal is given time to run before the cpu is moved onto it
        repeat (100) @(posedge clk);
        wr(8'h0C, 32'h00);
        // the old source stays on until the switch has happened
        repeat (50) @(posedge clk);
        wr(8'h10, 32'h00);
        runs(7, 1'b0);
        pc(0, 10, 0);
        rd(8'h1C, 32'h21, 32'h3F);
        wr(8'h08, 32'h00);
        stopMode <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h00, 32'h40, 32'hFF);
        stopMode <= 1'b0;
        pc(0, 80, 600);
        wr(8'h18, 32'h80);
        runs(6, 1'b1);
        wr(8'h18, 32'h00);
        rd(8'h18, 32'h80, 32'hFF);
        apb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0);
        chk(32'(err), 32'h1);
        stop_test();
    end
endmodule : tb_system_clock_divider_and_mode_select
